// >>> src/angs_sensor.sv
// sensor end of the angle sensor spi link: register access, crc, frame checks
//
// Contract
// RULE1: mode 3, sample rising, change falling
// RULE2: frames of 16, 17, 20 or 21 bits
// RULE3: 17-bit frame needs its enable bit
// RULE4: late-sampling host needs 17 clocks, enable first
// RULE5: excess clocks raise interface warning
// RULE6: 21-bit frame repeats crc msb last
// RULE7: write is 0, rw, addr6, data8, crc
// RULE8: full register needs two byte writes
// RULE9: mosi captured on sclk rising edge
// RULE10: read result comes in next frame
// RULE11: new read accepted while shifting out
// RULE12: all-zero command reads zero, no effect
// RULE13: host drops data without prior read
// RULE14: even address word, odd address byte
// RULE15: over 16 bits out appends crc
// RULE16: host crc ignored unless check enabled
// RULE17: bad crc discards frame, sets flag
// RULE18: crc x4+x+1, preset ones, msb first
// RULE19: crc feedback and shift per bit
// RULE20: host waits for extended read done
// RULE21: frame from cs fall to rise
`timescale 1ns/1ps
`include "angs_consts.svh"

module angs_sensor
	import angs_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	angs_if.sensor           spi,
	input  wire logic [1:0]  i_cfg,        // [1] seventeen_bit_frame_enable, [0] host_crc_check_enable
	output logic [5:0]       o_wr_addr,
	output logic [7:0]       o_wr_data,
	output logic             o_wr_strobe,
	output logic [5:0]       o_rd_addr,
	input  wire logic [15:0] i_rd_word,    // register pair at o_rd_addr & ~1, same-cycle
	output logic             o_warn_ier,
	output logic             o_warn_crc,
	input  wire logic        i_clr_warn
);

	typedef struct packed {
		logic [1:0]  sclk_s1;
		logic [1:0]  cs_s1;
		logic [1:0]  mosi_s;
		logic        sclk_d;
		logic        cs_d;
		logic        in_frame;
		logic [4:0]  bits;
		logic [20:0] rx;
		logic [15:0] tx;
		logic [3:0]  tx_crc;
		logic [3:0]  rx_crc;
		logic        miso;
		logic [5:0]  rd_addr;
		logic [15:0] rd_word;
		logic [5:0]  wr_addr;
		logic [7:0]  wr_data;
		logic        wr_strobe;
		logic        ier;
		logic        crc_err;
	} angs_sens_type;

	angs_sens_type st_reg;
	angs_sens_type st_next;

	logic sclk_s;
	logic cs_s;
	logic mosi_in;
	logic rise;
	logic fall;
	logic frame_ok;
	logic len_ok;
	logic crc_ok;
	logic [4:0] nbits;
	logic [15:0] cmd;

	// -------------------------------------------------------------------------
	// synchronised pins and edge detection
	// -------------------------------------------------------------------------
	assign sclk_s  = st_reg.sclk_s1[1];
	assign cs_s    = st_reg.cs_s1[1];
	assign mosi_in = st_reg.mosi_s[1];
	assign rise    = sclk_s & ~st_reg.sclk_d & ~cs_s;   // [RULE1] [RULE9]
	assign fall    = ~sclk_s & st_reg.sclk_d & ~cs_s;   // [RULE1]

	// -------------------------------------------------------------------------
	// combined next-state logic
	// -------------------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		nbits             = st_reg.bits;
		cmd               = 16'h0000;
		len_ok            = 1'b0;
		crc_ok            = 1'b1;
		frame_ok          = 1'b0;
		st_next.wr_strobe = 1'b0;
		// two-flop synchronisers; second stage only feeds logic
		st_next.sclk_s1 = {st_reg.sclk_s1[0], spi.sclk};
		st_next.cs_s1   = {st_reg.cs_s1[0], spi.cs_n};
		st_next.mosi_s  = {st_reg.mosi_s[0], spi.mosi};
		st_next.sclk_d  = sclk_s;
		st_next.cs_d    = cs_s;

		// clear first, so a set later in this cycle wins
		if (i_clr_warn) begin
			st_next.ier     = 1'b0;
			st_next.crc_err = 1'b0;
		end

		// frame start: reset counters, load the pending read result
		if (st_reg.cs_d && !cs_s) begin
			st_next.in_frame = 1'b1;                      // [RULE21]
			st_next.bits     = 5'h00;
			st_next.rx       = 21'h000000;
			st_next.rx_crc   = `ANGS_CRC_PRESET;
			st_next.tx       = st_reg.rd_word;            // [RULE10]
			st_next.tx_crc   = `ANGS_CRC_PRESET;
			st_next.miso     = st_reg.rd_word[15];
		end

		// capture on rising edge; host crc runs over first 16 bits
		if (rise && st_reg.in_frame) begin
			st_next.rx = {st_reg.rx[19:0], mosi_in};      // [RULE9]
			if (st_reg.bits < `ANGS_LEN_16) begin
				st_next.rx_crc = angs_crc_step(st_reg.rx_crc, mosi_in);   // [RULE18] [RULE19]
			end
			if (st_reg.bits != 5'h1F) begin
				st_next.bits = st_reg.bits + 5'h01;
			end
		end

		// shift out on falling edge: data msb first, then crc c3..c0; the crc
		// rotates back to where it began, so a 21st clock repeats c3
		if (fall && st_reg.in_frame) begin
			if (st_reg.bits < `ANGS_LEN_16) begin
				st_next.tx_crc = angs_crc_step(st_reg.tx_crc, st_reg.tx[15]);   // [RULE18]
				st_next.tx     = {st_reg.tx[14:0], 1'b0};
				st_next.miso   = st_reg.tx[15];           // [RULE1]
			end else if (st_reg.bits < `ANGS_LEN_21) begin
				st_next.tx_crc = {st_reg.tx_crc[2:0], st_reg.tx_crc[3]};
				st_next.miso   = st_reg.tx_crc[3];        // [RULE15] [RULE6]
			end
		end

		// frame end: judge length and crc, then act on the command
		if (!st_reg.cs_d && cs_s && st_reg.in_frame) begin
			st_next.in_frame = 1'b0;
			nbits = st_reg.bits;
			unique case (nbits)
				`ANGS_LEN_16: begin
					cmd    = st_reg.rx[15:0];
					len_ok = 1'b1;                        // [RULE2]
				end
				`ANGS_LEN_17: begin
					cmd    = st_reg.rx[16:1];
					len_ok = i_cfg[`ANGS_CFG_S17_BIT];    // [RULE3] [RULE4]
				end
				`ANGS_LEN_20: begin
					cmd    = st_reg.rx[19:4];
					len_ok = 1'b1;
					crc_ok = ~i_cfg[`ANGS_CFG_HOST_CRC_BIT] |
					         (st_reg.rx[3:0] == st_reg.rx_crc);   // [RULE16]
				end
				`ANGS_LEN_21: begin
					cmd    = st_reg.rx[20:5];
					len_ok = ~st_reg.rx[0];               // [RULE6] trailing bit must be zero
					crc_ok = ~i_cfg[`ANGS_CFG_HOST_CRC_BIT] |
					         (st_reg.rx[4:1] == st_reg.rx_crc);   // [RULE16]
				end
				default: begin
					cmd    = 16'h0000;
					len_ok = 1'b0;
				end
			endcase
			frame_ok = len_ok & crc_ok;
			if (!len_ok && nbits > `ANGS_LEN_16) begin
				st_next.ier = 1'b1;                       // [RULE5]
			end
			if (len_ok && !crc_ok) begin
				st_next.crc_err = 1'b1;                   // [RULE17] frame discarded
			end
			// leading bit must be zero; rw high writes, else read
			if (frame_ok && !cmd[15]) begin
				if (cmd[14]) begin
					st_next.wr_addr   = cmd[13:8];        // [RULE7] [RULE8]
					st_next.wr_data   = cmd[7:0];
					st_next.wr_strobe = 1'b1;
				end else begin
					st_next.rd_addr = cmd[13:8];          // [RULE11] [RULE12]
				end
			end
		end

		// fetch the read word one cycle after the address settles
		if (st_reg.rd_addr == 6'h00) begin
			st_next.rd_word = 16'h0000;                   // [RULE12]
		end else if (st_reg.rd_addr[0]) begin
			st_next.rd_word = {8'h00, i_rd_word[7:0]};    // [RULE14]
		end else begin
			st_next.rd_word = i_rd_word;                  // [RULE14]
		end

	end

	// -------------------------------------------------------------------------
	// state register
	// -------------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg         <= '0;
			st_reg.sclk_s1 <= 2'h3;
			st_reg.cs_s1   <= 2'h3;
			st_reg.sclk_d  <= 1'b1;
			st_reg.cs_d    <= 1'b1;
			st_reg.miso    <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign spi.miso    = st_reg.miso;
	assign o_wr_addr   = st_reg.wr_addr;
	assign o_wr_data   = st_reg.wr_data;
	assign o_wr_strobe = st_reg.wr_strobe;
	assign o_rd_addr   = {st_reg.rd_addr[5:1], 1'b0};
	assign o_warn_ier  = st_reg.ier;
	assign o_warn_crc  = st_reg.crc_err;

endmodule

// >>> common/angs_consts.svh
// constants shared by both ends of the angle sensor spi link
`ifndef ANGS_CONSTS_SVH
`define ANGS_CONSTS_SVH

// -------------------------------------------------------------------------
// frame lengths and crc preset
// -------------------------------------------------------------------------
`define ANGS_LEN_16        5'h10
`define ANGS_LEN_17        5'h11
`define ANGS_LEN_20        5'h14
`define ANGS_LEN_21        5'h15
`define ANGS_CRC_PRESET    4'hF

// -------------------------------------------------------------------------
// configuration word bits
// -------------------------------------------------------------------------
`define ANGS_CFG_HOST_CRC_BIT  0
`define ANGS_CFG_S17_BIT       1

// -------------------------------------------------------------------------
// host timing: timer reloads, each phase lasts one cycle longer than its count
// -------------------------------------------------------------------------
`define ANGS_HALF_PERIOD   8'h09
`define ANGS_CS_SETUP      8'h0A
`define ANGS_CS_IDLE       8'h28

// -------------------------------------------------------------------------
// host register map (word index on the plain port)
// -------------------------------------------------------------------------
`define ANGS_HREG_CMD      4'h0
`define ANGS_HREG_CTRL     4'h1
`define ANGS_HREG_RX       4'h2
`define ANGS_HREG_STATUS   4'h3

`endif

// >>> common/angs_pkg.sv
// types shared by both ends of the angle sensor spi link
package angs_pkg;

	typedef enum logic [1:0] {
		ANGS_H_IDLE,
		ANGS_H_SETUP,
		ANGS_H_SHIFT,
		ANGS_H_GAP
	} angs_hstate_type;

	// crc step: feedback is input xor c3, then shift with tap into c1
	function automatic logic [3:0] angs_crc_step(input logic [3:0] c, input logic b);
		logic fb;
		fb = b ^ c[3];
		return {c[2], c[1], c[0] ^ fb, fb};
	endfunction

endpackage

// >>> common/angs_if.sv
// four wire spi link between host controller and angle sensor
`timescale 1ns/1ps
interface angs_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;

	modport sensor (input sclk, input cs_n, input mosi, output miso);
	modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface

// >>> src/angs_host.sv
// host controller end of the angle sensor spi link, driven from a plain register port
`timescale 1ns/1ps
`include "angs_consts.svh"

module angs_host
	import angs_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	angs_if.host             spi,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	output logic             o_busy
);

	typedef struct packed {
		angs_hstate_type state;
		logic [4:0]  len;
		logic        auto_crc;
		logic [4:0]  bits;
		logic [7:0]  tmr;
		logic [20:0] tx;
		logic [20:0] rx;
		logic [1:0]  miso_s;
		logic        sclk;
		logic        cs_n;
		logic        mosi;
		logic        done;
		logic [31:0] rdata;
		logic        busy;
	} angs_host_type;

	angs_host_type st_reg;
	angs_host_type st_next;
	logic [3:0] crc;

	// -------------------------------------------------------------------------
	// outgoing crc over the command word
	// -------------------------------------------------------------------------
	always_comb begin
		crc = `ANGS_CRC_PRESET;
		for (int i = 15; i >= 0; i--) begin
			crc = angs_crc_step(crc, i_wdata[i]);         // [RULE18] [RULE19]
		end
	end

	// -------------------------------------------------------------------------
	// frame sequencer and register port
	// -------------------------------------------------------------------------
	always_comb begin
		st_next        = st_reg;
		st_next.rdata  = 32'h00000000;
		st_next.miso_s = {st_reg.miso_s[0], spi.miso};
		if (i_wr && i_addr == `ANGS_HREG_CTRL) begin
			st_next.len      = i_wdata[4:0];
			st_next.auto_crc = i_wdata[8];
		end
		if (i_rd) begin
			unique case (i_addr)
				`ANGS_HREG_CTRL:   st_next.rdata = {23'h000000, st_reg.auto_crc, 3'h0, st_reg.len};
				`ANGS_HREG_RX:     st_next.rdata = {11'h000, st_reg.rx};
				`ANGS_HREG_STATUS: st_next.rdata = {30'h00000000, st_reg.done, st_reg.state != ANGS_H_IDLE};
				default:           st_next.rdata = 32'h00000000;
			endcase
			if (i_addr == `ANGS_HREG_RX) begin
				st_next.done = 1'b0;
			end
		end
		unique case (st_reg.state)
			ANGS_H_IDLE: begin
				// a command is ignored while a frame runs
				if (i_wr && i_addr == `ANGS_HREG_CMD) begin
					st_next.tx    = {i_wdata[15:0], st_reg.auto_crc ? crc : i_wdata[19:16], 1'b0};   // [RULE6] [RULE7]
					st_next.cs_n  = 1'b0;                     // [RULE21]
					st_next.tmr   = `ANGS_CS_SETUP;
					st_next.bits  = 5'h00;
					st_next.rx    = 21'h000000;
					st_next.state = ANGS_H_SETUP;
				end
			end
			ANGS_H_SETUP: begin
				st_next.tmr = st_reg.tmr - 8'h01;
				if (st_reg.tmr == 8'h00) begin
					st_next.tmr   = `ANGS_HALF_PERIOD;
					st_next.state = ANGS_H_SHIFT;
				end
			end
			ANGS_H_SHIFT: begin
				st_next.tmr = st_reg.tmr - 8'h01;
				if (st_reg.tmr == 8'h00) begin
					st_next.tmr  = `ANGS_HALF_PERIOD;
					st_next.sclk = ~st_reg.sclk;
					if (st_reg.sclk) begin
						// falling edge: present next bit [RULE1]
						st_next.mosi = st_reg.tx[20];
						st_next.tx   = {st_reg.tx[19:0], 1'b0};
					end else begin
						// rising edge: sample miso [RULE1]
						st_next.rx   = {st_reg.rx[19:0], st_reg.miso_s[1]};
						st_next.bits = st_reg.bits + 5'h01;
						// select stays low a half period past the last rise, so the
						// far end counts that rise before it sees select go high
						if (st_reg.bits + 5'h01 == st_reg.len) begin
							st_next.tmr   = `ANGS_CS_IDLE + `ANGS_HALF_PERIOD;
							st_next.state = ANGS_H_GAP;
						end
					end
				end
			end
			ANGS_H_GAP: begin
				st_next.tmr = st_reg.tmr - 8'h01;
				if (st_reg.tmr == `ANGS_CS_IDLE) begin
					st_next.cs_n = 1'b1;                      // [RULE21]
				end
				if (st_reg.tmr == 8'h00) begin
					st_next.done  = 1'b1;                     // [RULE13] software decides use
					st_next.state = ANGS_H_IDLE;
				end
			end
		endcase
		// busy comes from a flop like every other output
		st_next.busy = (st_next.state != ANGS_H_IDLE);
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg        <= '0;
			st_reg.state  <= ANGS_H_IDLE;
			st_reg.len    <= `ANGS_LEN_16;
			st_reg.sclk   <= 1'b1;
			st_reg.cs_n   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign spi.sclk = st_reg.sclk;
	assign spi.cs_n = st_reg.cs_n;
	assign spi.mosi = st_reg.mosi;
	assign o_rdata  = st_reg.rdata;
	assign o_busy   = st_reg.busy;

endmodule

// >>> testbench/angs_link_monitor.sv
// concurrent checks on the four wire link between host end and sensor end
`timescale 1ns/1ps
module angs_link_monitor (
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso
);
	// ---------------------------------------------------------------
	// helper state: rising sclk count and bits seen at each rise
	// ---------------------------------------------------------------
	logic        sclk_q;
	logic [4:0]  bit_cnt;
	logic [20:0] miso_sr;
	logic        mosi_last;

	function automatic logic [3:0] crc16(input logic [15:0] d);
		logic [3:0] c;
		c = 4'hF;
		for (int i = 15; i >= 0; i--)
			c = {c[2], c[1], c[0] ^ d[i] ^ c[3], d[i] ^ c[3]};
		return c;
	endfunction

	// count restarts while deselected so every frame is judged alone
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_q <= 1'b1;
			bit_cnt <= 5'h00;
			miso_sr <= 21'h000000;
			mosi_last <= 1'b0;
		end else begin
			sclk_q <= sclk;
			if (cs_n) begin
				bit_cnt <= 5'h00;
			end else if (sclk && !sclk_q) begin
				bit_cnt <= bit_cnt + 5'h01;
				miso_sr <= {miso_sr[19:0], miso};
				mosi_last <= mosi;
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	sequence s_cs_fall;
		$fell(cs_n);
	endsequence
	sequence s_end21;
		$rose(cs_n) && bit_cnt == 5'h15;
	endsequence
	property p_idle_high; cs_n && $past(cs_n) |-> sclk; endproperty
	property p_mosi_hold; !cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(mosi); endproperty
	property p_miso_hold; !cs_n && !$past(cs_n, 8) && sclk && $past(sclk) |-> $stable(miso); endproperty
	property p_low_phase; $fell(sclk) |-> !sclk [*8]; endproperty
	property p_setup; s_cs_fall |-> (sclk && !cs_n) [*8]; endproperty
	property p_frame_end; s_cs_fall |-> ##[1:600] $rose(cs_n); endproperty
	property p_len; $rose(cs_n) |-> bit_cnt inside {5'h10, 5'h11, 5'h14, 5'h15}; endproperty
	property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
	property p_pad_zero; s_end21 |-> !mosi_last; endproperty
	property p_crc_rep; s_end21 |-> miso_sr[0] == miso_sr[4]; endproperty
	property p_crc_out; $rose(cs_n) && bit_cnt == 5'h14 |-> miso_sr[3:0] == crc16(miso_sr[19:4]); endproperty

	a_idle_high: assert property (p_idle_high) else $error("sclk low while deselected");
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");
	a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sclk high");
	a_low_phase: assert property (p_low_phase) else $error("sclk low phase too short");
	a_setup: assert property (p_setup) else $error("sclk edge too soon after select");
	a_frame_end: assert property (p_frame_end) else $error("frame did not end");
	a_len: assert property (p_len) else $error("frame length not allowed");
	a_gap: assert property (p_gap) else $error("deselect gap too short");
	a_pad_zero: assert property (p_pad_zero) else $error("last host bit of long frame not zero");
	a_crc_rep: assert property (p_crc_rep) else $error("crc msb not repeated");
	a_crc_out: assert property (p_crc_out) else $error("returned crc wrong");
endmodule

// >>> testbench/test_angle_sensor_spi_slave_frames.sv
// self-checking bench: host end drives sensor end across the link
`timescale 1ns/1ps
module test_angle_sensor_spi_slave_frames;
	// ---------------------------------------------------------------
	// signals, backing byte store and model state
	// ---------------------------------------------------------------
	logic        i_sys_clk, i_rst, i_wr, i_rd, o_busy, i_clr_warn, o_wr_strobe, o_warn_ier, o_warn_crc;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, seed;
	logic [1:0]  i_cfg;
	logic [5:0]  o_wr_addr, o_rd_addr, a;
	logic [7:0]  o_wr_data;
	logic [15:0] i_rd_word;
	logic [7:0]  dev_mem [64];
	int          mdl_mem [64];
	int          wr_seen, wr_exp, pend, mismatches, tests_run;
	logic        exp_ier, exp_crc;
	logic [4:0]  lens [4] = '{5'h10, 5'h14, 5'h15, 5'h11};

	angs_if link();
	angs_host angs_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .spi(link.host), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy));
	angs_sensor angs_sensor_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .spi(link.sensor), .i_cfg(i_cfg),
		.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_wr_strobe(o_wr_strobe), .o_rd_addr(o_rd_addr),
		.i_rd_word(i_rd_word), .o_warn_ier(o_warn_ier), .o_warn_crc(o_warn_crc), .i_clr_warn(i_clr_warn));
	angs_link_monitor angs_link_monitor_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .sclk(link.sclk),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

	// register pair behind the sensor; bytes 0 and 1 hold junk on purpose
	assign i_rd_word = {dev_mem[{o_rd_addr[5:1], 1'b0}], dev_mem[{o_rd_addr[5:1], 1'b1}]};
	always @(posedge i_sys_clk) begin
		if (o_wr_strobe) begin
			dev_mem[o_wr_addr] <= o_wr_data;
			wr_seen <= wr_seen + 1;
		end
	end

	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [3:0] crc(input logic [15:0] d);
		logic [3:0] c;
		c = 4'hF;
		for (int i = 15; i >= 0; i--)
			c = {c[2], c[1], c[0] ^ d[i] ^ c[3], d[i] ^ c[3]};
		return c;
	endfunction

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= ad;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic set_in(input logic [1:0] cfg, input logic clr);
		@(posedge i_sys_clk);
		i_cfg <= cfg;
		i_clr_warn <= clr;
		@(posedge i_sys_clk);
		i_clr_warn <= 1'b0;
		if (clr) {exp_ier, exp_crc} = 2'b00;
	endtask
	// one frame; the reply is held against the model of the previous command
	task automatic frame(input logic [15:0] cmd, input logic [4:0] len, input logic auto, input logic [3:0] mc);
		logic [31:0] rx;
		logic [3:0]  c;
		logic [5:0]  ra;
		logic        ok;
		int          n;
		bus_wr(4'h1, {23'h0, auto, 3'h0, len});
		bus_wr(4'h0, {12'h0, mc, cmd});
		repeat (2) @(posedge i_sys_clk);
		for (n = 0; o_busy !== 1'b0 && n < 2000; n++) @(posedge i_sys_clk);
		repeat (60) @(posedge i_sys_clk);
		@(posedge i_sys_clk);
		i_addr <= 4'h2;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 rx = o_rdata;
		check("idle", o_busy, 1'b0);
		ok = (len != 5'h11 || i_cfg[1]) && !(i_cfg[0] && !auto && len >= 5'h14 && mc != crc(cmd));
		if (len == 5'h11 && !i_cfg[1]) exp_ier = 1'b1;
		if (!ok && len != 5'h11) exp_crc = 1'b1;
		if (pend >= 0) begin
			c = crc(pend[15:0]);
			check("rx", rx & ((32'h1 << len) - 1), {pend[15:0], c, c[3]} >> (5'h15 - len));
		end
		check("wr", wr_seen, wr_exp + (ok && cmd[14]));
		check("ier", o_warn_ier, exp_ier);
		check("crc", o_warn_crc, exp_crc);
		ra = cmd[13:8];
		pend = -1;
		if (ok && cmd[14]) begin
			mdl_mem[ra] = cmd[7:0];
			wr_exp++;
		end else if (ok) begin
			pend = (ra == 6'h00) ? 0 : ra[0] ? mdl_mem[ra] : (mdl_mem[ra] << 8) | mdl_mem[ra | 6'h01];
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		{i_rst, i_addr, i_wdata, i_wr, i_rd, i_cfg, i_clr_warn} = {1'b1, 41'h0};
		{exp_ier, exp_crc} = 2'b00;
		wr_seen = 0;
		wr_exp = 0;
		pend = -1;
		mismatches = 0;
		tests_run = 0;
		seed = 32'h1D03B03A;
		for (int i = 0; i < 64; i++) begin
			dev_mem[i] = 8'h00;
			mdl_mem[i] = 0;
		end
		dev_mem[0] = 8'hA5;
		dev_mem[1] = 8'h5A;
		repeat (8) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		// byte writes to both halves, then duplexed even and odd reads
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			a = {seed[5:1] | 5'h01, 1'b0};
			set_in({i == 3, 1'b0}, 1'b0);
			frame({2'b01, a, seed[15:8]}, 5'h14, 1'b1, 4'h0);
			frame({2'b01, a | 6'h01, seed[23:16]}, 5'h10, 1'b1, 4'h0);
			frame({2'b00, a, 8'h00}, lens[i], 1'b1, 4'h0);
			frame({2'b00, a | 6'h01, 8'h00}, lens[i], 1'b1, 4'h0);
			frame(16'h0000, lens[i], 1'b1, 4'h0);
			frame(16'h0000, 5'h14, 1'b1, 4'h0);
		end
		$display("test done: writes and duplexed reads");
		// excess clock without the long frame enable, then clear
		set_in(2'b00, 1'b0);
		frame({2'b01, 6'h08, 8'h3C}, 5'h11, 1'b1, 4'h0);
		set_in(2'b00, 1'b1);
		frame({2'b01, 6'h08, 8'h3C}, 5'h10, 1'b1, 4'h0);
		$display("test done: excess clock warning");
		// host crc: wrong and right with the check on, wrong with it off
		set_in(2'b01, 1'b0);
		frame({2'b01, 6'h0A, seed[7:0]}, 5'h14, 1'b0, crc({2'b01, 6'h0A, seed[7:0]}) ^ 4'h1);
		frame({2'b01, 6'h0B, seed[7:0]}, 5'h14, 1'b0, crc({2'b01, 6'h0B, seed[7:0]}));
		set_in(2'b00, 1'b1);
		frame({2'b01, 6'h0A, seed[15:8]}, 5'h14, 1'b0, 4'h0);
		frame({2'b00, 6'h0A, 8'h00}, 5'h14, 1'b1, 4'h0);
		frame(16'h0000, 5'h15, 1'b1, 4'h0);
		$display("test done: host crc check");
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge i_sys_clk);
		mismatches++;
		wrap_up();
	end
endmodule
